// File: logic/acr_ctrl.sv
// Converter control block: control/status register, reference control register,
// start-of-conversion trigger selection and window compare flag.
// Assumes the special-function bus, timer strobes and convert pin are synchronous to ref_clk.
// Assumes the core raises its done level after a single conversion or a whole burst and drops it at the next start.
// Assumes the window limits stay stable while the core finishes a conversion.
`timescale 1ns/1ps
`include "acr_defs.svh"

// Contract
// RL1 - Reference select 00 routes the external reference pin to the converter.
// RL2 - Reference select 11 uses the internal high-speed reference.
// RL3 - Internal reference powers up and down automatically while converter needs it.
// RL4 - Level bit chooses internal reference 1.65 V or 2.4 V.
// RL5 - Select 01 uses main supply; 10 uses 1.8 V regulated supply.
// RL6 - Internal reference sources never reach the external reference pin.
// RL7 - Ground select 1 takes ground from analog ground pin, tracking and converting.
// RL8 - Temperature sensor sampling always uses internal chip ground.
// RL9 - Internal 1.65 V reference forces chip ground during conversion.
// RL10 - Temperature sensor enable bit; cleared leaves sensor output high impedance.
// RL11 - Bit 7 enables converter; zero means low-power shutdown.
// RL12 - Bit 6 enables or disables burst mode.
// RL13 - Hardware sets bit 5 after a conversion, or a whole burst in burst mode.
// RL14 - Done and window flags raise interrupts; only software clears them.
// RL15 - Writing 1 to bit 4 starts conversion when start source is 000.
// RL16 - Software polls the done flag, not the busy bit, for completion.
// RL17 - Hardware sets bit 3 when the result satisfies the window limits.
// RL18 - Bits 2:0 select trigger: software, timer 0, 2, 3, pin edge.
// RL19 - Software must not write start source codes 101 through 111.
// RL20 - Control register at address E8, bit-addressable.
// RL21 - Less limit above greater limit: flag when result strictly inside both.
// RL22 - Less limit below greater limit: flag when result outside strictly.
// RL23 - Reserved start source code ignores all triggers.
// RL24 - Each trigger event starts one conversion, only while enabled or bursting. The code drops events that arrive while busy.
module acr_ctrl #(
    parameter int RES_W = 16
) (
    // Clock and reset.
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Special-function-register bus.
    input  wire acr_pkg::acr_sfr_req_t   sfr_req,
    input  wire logic [7:0]              sfr_rd_addr,
    output logic [7:0]                   sfr_rdata,
    // Window limits supplied by the limit registers elsewhere.
    input  wire logic [RES_W-1:0]        greater_limit,
    input  wire logic [RES_W-1:0]        less_limit,
    // Trigger sources.
    input  wire logic                    timer0_ovf,
    input  wire logic                    timer2_ovf,
    input  wire logic                    timer3_ovf,
    input  wire logic                    external_convert_pin,
    // Analog converter core.
    output acr_pkg::acr_core_ctl_t       core_ctl,
    input  wire acr_pkg::acr_core_stat_t core_stat,
    // Interrupt request lines.
    output logic                         done_irq,
    output logic                         window_irq,
    // Analog routing controls.
    output logic                         ext_ref_pin_connect,
    output logic                         temp_sensor_out_en,
    output logic                         chip_ground_select
);
    import acr_pkg::*;

    logic       rst_meta_r;
    logic       rst_sync_r;
    logic       converter_enable_r;
    logic       burst_mode_enable_r;
    logic       conversion_done_flag_r;
    logic       busy_r;
    logic       window_match_flag_r;
    logic [2:0] start_source_select_r;
    logic [1:0] reference_source_select_r;
    logic       ground_source_select_r;
    logic       internal_reference_level_r;
    logic       temp_sensor_enable_r;
    logic       pin_prev_r;
    logic       start_r;
    logic       done_prev_r;

    logic       ccs_byte_wr;
    logic       ccs_bit_wr;
    logic       ref_byte_wr;
    logic [7:0] ccs_cur;
    logic [7:0] ccs_wr_val;
    logic [7:0] ccs_wr_mask;
    logic       soft_start;
    logic       trig_event;
    logic       trig_nxt;
    logic       done_evt;
    logic       window_hit;
    logic       window_evt;
    logic       trig_open;
    logic       pin_rise;
    logic       int_ref_selected;
    logic       low_ref_selected;
    logic       converter_active;

    // Reset is released through two flip-flops.
    // Only the second one feeds the design, so a release near an edge never splits the register set.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Byte writes and single-bit writes both land in the control register.
    assign ccs_byte_wr = sfr_req.wr_en && !sfr_req.bit_wr && (sfr_req.addr == `ACR_CCS_ADDR); // RL20
    assign ccs_bit_wr  = sfr_req.wr_en && sfr_req.bit_wr && (sfr_req.addr == `ACR_CCS_ADDR);  // RL20
    assign ref_byte_wr = sfr_req.wr_en && !sfr_req.bit_wr && (sfr_req.addr == `ACR_REF_ADDR);

    // Present control register contents: the read value and the base that a bit write patches.
    assign ccs_cur = {converter_enable_r, burst_mode_enable_r, conversion_done_flag_r, busy_r,
                      window_match_flag_r, start_source_select_r};

    always_comb begin
        ccs_wr_mask = 8'h00;
        ccs_wr_val  = ccs_cur;
        if (ccs_byte_wr) begin
            ccs_wr_mask = 8'hFF;
            ccs_wr_val  = sfr_req.wdata;
        end else if (ccs_bit_wr) begin
            ccs_wr_mask                  = 8'h01 << sfr_req.bit_sel; // RL20
            ccs_wr_val[sfr_req.bit_sel]  = sfr_req.wdata[0];
        end
    end

    // Converter enable; zero parks the converter in low-power shutdown once no conversion is busy.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            converter_enable_r <= 1'b0;
        end else if (ccs_wr_mask[`ACR_BIT_ENABLE]) begin
            converter_enable_r <= ccs_wr_val[`ACR_BIT_ENABLE]; // RL11
        end
    end

    // Burst mode enable, passed straight to the core.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            burst_mode_enable_r <= 1'b0;
        end else if (ccs_wr_mask[`ACR_BIT_BURST]) begin
            burst_mode_enable_r <= ccs_wr_val[`ACR_BIT_BURST]; // RL12
        end
    end

    // Start source select; a bit write changes one bit and leaves the other two alone.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            start_source_select_r <= `ACR_SRC_SOFT;
        end else if (ccs_wr_mask[2:0] == 3'h7) begin
            start_source_select_r <= ccs_wr_val[2:0]; // RL18
        end else if (ccs_wr_mask[2:0] != 3'h0) begin
            start_source_select_r <= (start_source_select_r & ~ccs_wr_mask[2:0])
                                     | (ccs_wr_val[2:0] & ccs_wr_mask[2:0]);
        end
    end

    // Reference source select; reset picks the internal reference.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            reference_source_select_r <= `ACR_REF_SEL_INT;
        end else if (ref_byte_wr) begin
            reference_source_select_r <= sfr_req.wdata[`ACR_REF_SEL_LSB +: 2]; // RL1 RL2 RL5
        end
    end

    // Ground source select.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ground_source_select_r <= 1'b0;
        end else if (ref_byte_wr) begin
            ground_source_select_r <= sfr_req.wdata[`ACR_REF_BIT_GND]; // RL7
        end
    end

    // Internal reference level; zero is the lower level.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            internal_reference_level_r <= 1'b0;
        end else if (ref_byte_wr) begin
            internal_reference_level_r <= sfr_req.wdata[`ACR_REF_BIT_LVL]; // RL4
        end
    end

    // Temperature sensor enable.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            temp_sensor_enable_r <= 1'b0;
        end else if (ref_byte_wr) begin
            temp_sensor_enable_r <= sfr_req.wdata[`ACR_REF_BIT_TEMP]; // RL10
        end
    end

    // Trigger selection; reserved codes match no source.
    // A software start is a one written to the busy bit, by byte or by bit write.
    assign soft_start = ccs_wr_mask[`ACR_BIT_BUSY] && ccs_wr_val[`ACR_BIT_BUSY];
    // The pin is sampled as synchronous, so one flip-flop of history finds its rising edge.
    assign pin_rise   = external_convert_pin && !pin_prev_r; // RL18

    always_comb begin
        unique case (start_source_select_r)
            `ACR_SRC_SOFT: trig_event = soft_start;                         // RL15
            `ACR_SRC_TMR0: trig_event = timer0_ovf;                         // RL18
            `ACR_SRC_TMR2: trig_event = timer2_ovf;                         // RL18
            `ACR_SRC_TMR3: trig_event = timer3_ovf;                         // RL18
            `ACR_SRC_PIN:  trig_event = pin_rise;                           // RL18
            default:       trig_event = 1'b0;                               // RL23
        endcase
    end

    // One start pulse per event, only while enabled or bursting, never while busy.
    // Events that arrive while busy are dropped rather than queued, so nothing fires late.
    assign trig_open = (converter_enable_r || burst_mode_enable_r) && !busy_r;
    assign trig_nxt  = trig_event && trig_open; // RL24

    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= external_convert_pin;
        end
    end

    // Registered start pulse; busy blocks a second trigger, so it lasts one cycle.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            start_r <= 1'b0;
        end else begin
            start_r <= trig_nxt; // RL24
        end
    end

    // Busy is kept here, not taken from core_stat.busy; set with the start pulse so software sees it at once.
    // It clears on the done edge, the same edge that raises the completion flag.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            busy_r <= 1'b0;
        end else if (trig_nxt) begin
            busy_r <= 1'b1; // RL15
        end else if (done_evt) begin
            busy_r <= 1'b0;
        end
    end

    // The core's done level marks a single conversion or a whole burst finishing.
    assign done_evt = core_stat.done && !done_prev_r; // RL13

    // Window compare picks inside or outside by the order of the limits.
    // Equal limits take the outside case, where every result but the limit itself matches.
    always_comb begin
        if (less_limit > greater_limit) begin
            window_hit = (core_stat.result[RES_W-1:0] > greater_limit)
                         && (core_stat.result[RES_W-1:0] < less_limit); // RL21
        end else begin
            window_hit = (core_stat.result[RES_W-1:0] < less_limit)
                         || (core_stat.result[RES_W-1:0] > greater_limit); // RL22
        end
    end
    assign window_evt = done_evt && window_hit; // RL17

    // Previous core done level, for rising-edge detection.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            done_prev_r <= 1'b0;
        end else begin
            done_prev_r <= core_stat.done;
        end
    end

    // Completion flag: hardware only sets, software clears, and a set wins over a same-cycle clear.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            conversion_done_flag_r <= 1'b0;
        end else if (done_evt) begin
            conversion_done_flag_r <= 1'b1; // RL13
        end else if (ccs_wr_mask[`ACR_BIT_DONE]) begin
            conversion_done_flag_r <= ccs_wr_val[`ACR_BIT_DONE]; // RL14
        end
    end

    // Window flag: same set-wins rule as the completion flag.
    always_ff @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            window_match_flag_r <= 1'b0;
        end else if (window_evt) begin
            window_match_flag_r <= 1'b1; // RL17
        end else if (ccs_wr_mask[`ACR_BIT_WINDOW]) begin
            window_match_flag_r <= ccs_wr_val[`ACR_BIT_WINDOW]; // RL14
        end
    end

    assign done_irq   = conversion_done_flag_r; // RL14
    assign window_irq = window_match_flag_r;    // RL14

    // Register read mux; unmapped addresses read zero.
    // Bits 7:6 and 1 of the reference register are unused and read zero.
    always_comb begin
        if (sfr_rd_addr == `ACR_CCS_ADDR) begin
            sfr_rdata = ccs_cur;
        end else if (sfr_rd_addr == `ACR_REF_ADDR) begin
            sfr_rdata = {2'b00, ground_source_select_r, reference_source_select_r,
                         internal_reference_level_r, 1'b0, temp_sensor_enable_r};
        end else begin
            sfr_rdata = 8'h00;
        end
    end

    // Decoded reference choices shared by power and ground steering.
    assign int_ref_selected = (reference_source_select_r == `ACR_REF_SEL_INT); // RL2
    assign low_ref_selected = int_ref_selected && !internal_reference_level_r;  // RL9
    assign converter_active = converter_enable_r || busy_r;

    // Core control and analog routing.
    // The internal reference follows converter activity, so software never has to power it.
    always_comb begin
        unique case (reference_source_select_r)
            `ACR_REF_SEL_EXT:  core_ctl.ref_src = ACR_REF_EXTERNAL;  // RL1
            `ACR_REF_SEL_VDD:  core_ctl.ref_src = ACR_REF_SUPPLY;    // RL5
            `ACR_REF_SEL_VREG: core_ctl.ref_src = ACR_REF_REGULATED; // RL5
            `ACR_REF_SEL_INT:  core_ctl.ref_src = ACR_REF_INTERNAL;  // RL2
        endcase
        core_ctl.start        = start_r;
        core_ctl.burst        = burst_mode_enable_r;
        core_ctl.powered      = converter_active;
        core_ctl.int_ref_on   = int_ref_selected && converter_active; // RL3
        core_ctl.int_ref_high = internal_reference_level_r; // RL4
        core_ctl.temp_on      = temp_sensor_enable_r;       // RL10
        core_ctl.gnd_analog_pin = ground_source_select_r && !chip_ground_select; // RL7
    end

    // Only the external choice connects the reference pin; internal sources stay off it.
    assign ext_ref_pin_connect = (reference_source_select_r == `ACR_REF_SEL_EXT); // RL6
    assign temp_sensor_out_en  = temp_sensor_enable_r;                            // RL10

    // Chip ground overrides the pin for temp sampling and for 1.65 V conversions.
    assign chip_ground_select = (core_stat.temp_selected && core_stat.tracking)             // RL8
                                || (low_ref_selected && !core_stat.tracking);               // RL9

endmodule : acr_ctrl

// File: inc/acr_defs.svh
// Register addresses, field positions, reset values and codes for the converter control block.
// Assumes an 8-bit special-function-register bus with byte and single-bit write access.
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

`define ACR_CCS_ADDR        8'hE8
`define ACR_REF_ADDR        8'hD1
`define ACR_CCS_RESET       8'h00
`define ACR_REF_RESET       8'h18
`define ACR_BIT_ENABLE      3'd7
`define ACR_BIT_BURST       3'd6
`define ACR_BIT_DONE        3'd5
`define ACR_BIT_BUSY        3'd4
`define ACR_BIT_WINDOW      3'd3
`define ACR_REF_BIT_GND     3'd5
`define ACR_REF_BIT_LVL     3'd2
`define ACR_REF_BIT_TEMP    3'd0
`define ACR_REF_SEL_LSB     3
`define ACR_REF_SEL_EXT     2'b00
`define ACR_REF_SEL_VDD     2'b01
`define ACR_REF_SEL_VREG    2'b10
`define ACR_REF_SEL_INT     2'b11
`define ACR_SRC_SOFT        3'b000
`define ACR_SRC_TMR0        3'b001
`define ACR_SRC_TMR2        3'b010
`define ACR_SRC_TMR3        3'b011
`define ACR_SRC_PIN         3'b100

`endif

// File: inc/acr_pkg.sv
// Types shared by the converter control block.
// Assumes acr_defs.svh supplies the numeric constants.
package acr_pkg;

    typedef enum logic [1:0] {
        ACR_REF_EXTERNAL,
        ACR_REF_SUPPLY,
        ACR_REF_REGULATED,
        ACR_REF_INTERNAL
    } acr_ref_src_t;

    typedef struct packed {
        logic       wr_en;
        logic       bit_wr;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } acr_sfr_req_t;

    typedef struct packed {
        logic       start;
        logic       burst;
        logic       powered;
        logic       int_ref_on;
        logic       int_ref_high;
        logic       temp_on;
        logic       gnd_analog_pin;
        acr_ref_src_t ref_src;
    } acr_core_ctl_t;

    typedef struct packed {
        logic        done;
        logic        busy;
        logic        tracking;
        logic        temp_selected;
        logic [15:0] result;
    } acr_core_stat_t;

endpackage : acr_pkg

// File: test/acr_ctrl_asserts.sv
// Port-level checks for the converter control block.
// Assumes it is bound onto acr_ctrl and that rst_n is the only reset.
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_ctrl_asserts
    import acr_pkg::*;
(
    // Clock and reset.
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    // Register bus.
    input wire acr_pkg::acr_sfr_req_t   sfr_req,
    // Converter core.
    input wire acr_pkg::acr_core_ctl_t  core_ctl,
    input wire acr_pkg::acr_core_stat_t core_stat,
    // Flags and routing.
    input wire logic                    done_irq,
    input wire logic                    window_irq,
    input wire logic                    ext_ref_pin_connect,
    input wire logic                    temp_sensor_out_en,
    input wire logic                    chip_ground_select
);
    import acr_pkg::*;
    logic ccs_wr;
    assign ccs_wr = sfr_req.wr_en && (sfr_req.addr == `ACR_CCS_ADDR);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_EXT_REF: assert property (ext_ref_pin_connect == (core_ctl.ref_src == ACR_REF_EXTERNAL))
        else $error("external reference pin routing wrong");
    AST_INT_REF: assert property (core_ctl.int_ref_on |-> core_ctl.ref_src == ACR_REF_INTERNAL)
        else $error("internal reference powered while not selected");
    AST_TEMP_GND: assert property (core_stat.tracking && core_stat.temp_selected |-> chip_ground_select)
        else $error("sensor sampled without chip ground");
    AST_LOW_REF_GND: assert property (core_ctl.ref_src == ACR_REF_INTERNAL && !core_ctl.int_ref_high
        && !core_stat.tracking |-> chip_ground_select) else $error("low reference converts without chip ground");
    AST_TEMP_HIZ: assert property (temp_sensor_out_en == core_ctl.temp_on)
        else $error("sensor drive differs from its enable");
    AST_DONE_SET: assert property ($rose(core_stat.done) |=> done_irq)
        else $error("done flag not set after completion");
    AST_DONE_HOLD: assert property (done_irq && !ccs_wr |=> done_irq)
        else $error("done flag cleared without a write");
    AST_WIN_HOLD: assert property (window_irq && !ccs_wr |=> window_irq)
        else $error("window flag cleared without a write");
    AST_ONE_START: assert property (core_ctl.start |=> !core_ctl.start)
        else $error("start pulse longer than one cycle");
    AST_START_EN: assert property (core_ctl.start |-> $past(core_ctl.powered) || $past(core_ctl.burst))
        else $error("start while converter disabled");
endmodule : acr_ctrl_asserts

// File: test/acr_core_model.sv
// Behavioural model of the analog converter core behind the control block.
// Assumes one start pulse per conversion; a burst is answered as one conversion of the usual length.
`timescale 1ns/1ps
module acr_core_model
    import acr_pkg::*;
(
    // Clock and reset.
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    // Control side.
    input wire acr_pkg::acr_core_ctl_t core_ctl,
    input wire logic [15:0]            res_in,
    input wire logic                   temp_in,
    // Status side.
    output acr_pkg::acr_core_stat_t    core_stat
);
    import acr_pkg::*;
    logic [3:0] cnt_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r     <= 4'h0;
            core_stat <= '0;
        end else begin
            core_stat.temp_selected <= temp_in;
            if (core_ctl.start) begin
                cnt_r               <= 4'h6;
                core_stat.done      <= 1'b0;
                core_stat.busy      <= 1'b1;
                core_stat.tracking  <= 1'b1;
                // Result is not valid while converting, so show a different value.
                core_stat.result    <= ~res_in;
            end else if (cnt_r != 4'h0) begin
                cnt_r              <= cnt_r - 4'h1;
                core_stat.tracking <= (cnt_r > 4'h5);
                if (cnt_r == 4'h1) begin
                    core_stat.done   <= 1'b1;
                    core_stat.busy   <= 1'b0;
                    core_stat.result <= res_in;
                end
            end
        end
    end
endmodule : acr_core_model

// File: test/testbench.sv
// Self-checking bench for the converter control block.
// Assumes acr_core_model stands in for the analog core.
`timescale 1ns/1ps
`include "acr_defs.svh"
module testbench;
    import acr_pkg::*;
    logic ref_clk, rst_n, temp_in;
    acr_sfr_req_t   sfr_req;
    acr_core_ctl_t  core_ctl;
    acr_core_stat_t core_stat;
    logic [7:0]  rd_addr, rdata;
    logic [15:0] gt, lt, res;
    logic [3:0]  trig;
    logic done_irq, window_irq, ext_pin, ts_en, cgnd;
    int fail_count, comparisons, i;
    acr_ctrl #(.RES_W(16)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rd_addr(rd_addr),
        .sfr_rdata(rdata), .greater_limit(gt), .less_limit(lt), .timer0_ovf(trig[0]), .timer2_ovf(trig[1]),
        .timer3_ovf(trig[2]), .external_convert_pin(trig[3]), .core_ctl(core_ctl), .core_stat(core_stat),
        .done_irq(done_irq), .window_irq(window_irq), .ext_ref_pin_connect(ext_pin),
        .temp_sensor_out_en(ts_en), .chip_ground_select(cgnd));
    acr_core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .core_ctl(core_ctl), .res_in(res),
        .temp_in(temp_in), .core_stat(core_stat));
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bw = 1'b0, input logic [2:0] b = 3'h0);
        @(negedge ref_clk);
        sfr_req = '{wr_en: 1'b1, bit_wr: bw, addr: a, bit_sel: b, wdata: d};
        @(negedge ref_clk);
        sfr_req.wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        rd_addr = a;
        #1 chk("read data", e, rdata);
    endtask : rd
    task automatic pulse(input logic [3:0] m);
        @(negedge ref_clk);
        trig = m;
        @(negedge ref_clk);
        trig = 4'h0;
    endtask : pulse
    task automatic run();
        int k;
        for (k = 0; k < 6 && core_ctl.start !== 1'b1; k++) @(negedge ref_clk);
        chk("start", 8'h01, {7'h0, core_ctl.start});
        if (core_ctl.start !== 1'b1) stop_test();
        for (k = 0; k < 20 && done_irq !== 1'b1; k++) @(negedge ref_clk);
        chk("done_irq", 8'h01, {7'h0, done_irq});
        if (done_irq !== 1'b1) stop_test();
    endtask : run
    task automatic quiet();
        logic s;
        s = 1'b0;
        repeat (8) @(negedge ref_clk) s = s | core_ctl.start;
        chk("no start", 8'h00, {7'h0, s});
    endtask : quiet
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        rst_n = 1'b0; sfr_req = '0; rd_addr = 8'h00; gt = 16'h0; lt = 16'h0;
        trig = 4'h0; res = 16'h0; temp_in = 1'b0; fail_count = 0; comparisons = 0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk) rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd(`ACR_CCS_ADDR, 8'h00);
        rd(`ACR_REF_ADDR, 8'h18);
        rd(8'h55, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(`ACR_REF_ADDR, 8'((i << 3) | ((i & 1) << 2) | (i >> 1)));
            chk("ref_src", 8'(i), {6'h0, core_ctl.ref_src});
            chk("ext pin", {7'h0, i == 0}, {7'h0, ext_pin});
            chk("level", 8'(i & 1), {7'h0, core_ctl.int_ref_high});
            chk("temp en", 8'(i >> 1), {7'h0, ts_en});
        end
        wr(`ACR_REF_ADDR, 8'h28);
        chk("gnd pin", 8'h01, {7'h0, core_ctl.gnd_analog_pin});
        chk("chip gnd", 8'h00, {7'h0, cgnd});
        wr(`ACR_REF_ADDR, 8'h38);
        rd(`ACR_REF_ADDR, 8'h38);
        chk("chip gnd", 8'h01, {7'h0, cgnd});
        chk("gnd pin", 8'h00, {7'h0, core_ctl.gnd_analog_pin});
        wr(`ACR_CCS_ADDR, 8'h01, 1'b1, 3'h7);
        rd(`ACR_CCS_ADDR, 8'h80);
        chk("powered", 8'h01, {7'h0, core_ctl.powered});
        chk("int ref on", 8'h01, {7'h0, core_ctl.int_ref_on});
        gt = 16'h0040; lt = 16'h0080; res = 16'h0050;
        wr(`ACR_CCS_ADDR, 8'h90);
        run();
        rd(`ACR_CCS_ADDR, 8'hA8);
        chk("window_irq", 8'h01, {7'h0, window_irq});
        wr(`ACR_CCS_ADDR, 8'h80);
        rd(`ACR_CCS_ADDR, 8'h80);
        chk("window_irq", 8'h00, {7'h0, window_irq});
        gt = 16'h0080; lt = 16'h0040; temp_in = 1'b1;
        for (i = 1; i < 5; i++) begin
            res = (i & 1) ? 16'h0030 : 16'h0050;
            wr(`ACR_CCS_ADDR, 8'(8'h80 | i));
            pulse(4'(1 << (i - 1)));
            run();
            rd(`ACR_CCS_ADDR, 8'(8'hA0 | ((i & 1) << 3) | i));
            chk("window_irq", 8'(i & 1), {7'h0, window_irq});
        end
        wr(`ACR_CCS_ADDR, 8'h85);
        pulse(4'hF);
        quiet();
        wr(`ACR_CCS_ADDR, 8'h01);
        chk("int ref on", 8'h00, {7'h0, core_ctl.int_ref_on});
        pulse(4'h1);
        quiet();
        wr(`ACR_CCS_ADDR, 8'h41);
        chk("burst", 8'h01, {7'h0, core_ctl.burst});
        pulse(4'h1);
        run();
        rd(`ACR_CCS_ADDR, 8'h61);
        stop_test();
    end
endmodule : testbench
bind acr_ctrl acr_ctrl_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req), .core_ctl(core_ctl),
    .core_stat(core_stat), .done_irq(done_irq), .window_irq(window_irq), .ext_ref_pin_connect(ext_ref_pin_connect),
    .temp_sensor_out_en(temp_sensor_out_en), .chip_ground_select(chip_ground_select));
